/* common/act_pkg.sv */
// package for the converter timing control block: register map, fields, reset values, timings
package act_pkg;

  localparam logic [3:0]  ACT_OFF_PWR      = 4'h0;
  localparam logic [3:0]  ACT_OFF_SDEL     = 4'h1;
  localparam logic [3:0]  ACT_OFF_C0_LO    = 4'h2;
  localparam logic [3:0]  ACT_OFF_C0_HI    = 4'h3;
  localparam logic [3:0]  ACT_OFF_C1_LO    = 4'h4;
  localparam logic [3:0]  ACT_OFF_C1_HI    = 4'h5;
  localparam logic [3:0]  ACT_OFF_IRQ_STAT = 4'h6;
  localparam logic [3:0]  ACT_OFF_IRQ_MASK = 4'h7;
  localparam logic [3:0]  ACT_OFF_TRIG     = 4'h8;

  localparam int          ACT_RDY_BIT      = 15;
  localparam int          ACT_PWR_BIT      = 7;
  localparam int          ACT_EIS_LSB      = 10;
  localparam int          ACT_RES_LSB      = 8;
  localparam int          ACT_DIV_LSB      = 0;
  localparam logic [15:0] ACT_HI_MASK      = 16'h1F7F;
  localparam logic [15:0] ACT_SDEL_MASK    = 16'h0003;
  localparam logic [15:0] ACT_LO_MASK      = 16'h03FF;
  localparam logic [15:0] ACT_IRQ_MASK_W   = 16'h000F;
  localparam logic [15:0] ACT_RST_VAL      = 16'h0000;

  localparam int          ACT_CLK_HZ       = 25000000;
  localparam int          ACT_PWRUP_NS     = 10000;
  localparam int          ACT_PWRUP_CYC    = (ACT_PWRUP_NS * (ACT_CLK_HZ / 1000000) + 999) / 1000;

  localparam logic [4:0]  ACT_SAR_BASE     = 5'h02;

  typedef enum logic [1:0] {ACT_IDLE, ACT_SAMP, ACT_CONV} act_state_t;

  typedef struct packed {
    logic [2:0] eis;
    logic [1:0] res;
    logic [6:0] div;
    logic [9:0] sample_extend_count;
    logic       ext_en;
  } act_core_cfg_t;

  typedef struct packed {
    logic       sampling;
    logic       converting;
    logic       early_irq;
    logic       done;
  } act_core_evt_t;

endpackage

/* verilog/act_core_seq.sv */
// one dedicated converter core sequencer: clock divider, sample extension, conversion, early interrupt
`timescale 1ns/1ns
module act_core_seq
  import act_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire act_core_cfg_t cfg,
  input  wire logic          trig,
  output act_core_evt_t      evt
);

  typedef struct packed {
    act_state_t st;
    logic [7:0] pre;
    logic       tick;
    logic [9:0] cnt;
    logic [4:0] left;
    act_core_evt_t ev;
  } seq_t;

  seq_t s_r;
  seq_t s_nxt;
  logic [7:0] half;
  logic [4:0] conv_len;
  logic       wrap;

  assign evt = s_r.ev;

  always_comb begin
    half = (cfg.div < 7'h02) ? 8'h01 : {1'b0, cfg.div};
    wrap = (s_r.pre + 8'h01) >= (half << 1);
    unique case (cfg.res)
      2'b11:   conv_len = ACT_SAR_BASE + 5'h0C;
      2'b10:   conv_len = ACT_SAR_BASE + 5'h0A;
      2'b01:   conv_len = ACT_SAR_BASE + 5'h08;
      default: conv_len = ACT_SAR_BASE + 5'h06;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ev.done = 1'b0;
    s_nxt.ev.early_irq = 1'b0;
    // core clock held still while idle, so each trigger opens a whole core clock period
    // and a conversion always spans exactly its count of core clocks
    s_nxt.tick = 1'b0;
    if (s_r.st == ACT_IDLE) begin
      s_nxt.pre = 8'h00;
    end else if (wrap) begin
      s_nxt.pre = 8'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.pre = s_r.pre + 8'h01;
    end
    unique case (s_r.st)
      ACT_IDLE: begin
        s_nxt.ev.sampling = 1'b1;
        if (trig) begin
          if (cfg.ext_en && cfg.sample_extend_count != 10'h000) begin
            s_nxt.st = ACT_SAMP;
            s_nxt.cnt = cfg.sample_extend_count;
          end else begin
            s_nxt.st = ACT_CONV;
            s_nxt.ev.sampling = 1'b0;
            s_nxt.ev.converting = 1'b1;
            s_nxt.left = conv_len;
          end
        end
      end
      ACT_SAMP: if (wrap) begin
        s_nxt.cnt = s_r.cnt - 10'h001;
        if (s_r.cnt == 10'h001) begin
          s_nxt.st = ACT_CONV;
          s_nxt.ev.sampling = 1'b0;
          s_nxt.ev.converting = 1'b1;
          s_nxt.left = conv_len;
        end
      end
      ACT_CONV: begin
        s_nxt.ev.converting = 1'b1;
        if (wrap) begin
          s_nxt.left = s_r.left - 5'h01;
          // early interrupt fires eis+1 core clocks before data ready
          if (s_r.left == {2'b00, cfg.eis} + 5'h02) begin
            s_nxt.ev.early_irq = 1'b1;
          end
          if (s_r.left == 5'h01) begin
            s_nxt.st = ACT_IDLE;
            s_nxt.ev.converting = 1'b0;
            s_nxt.ev.sampling = 1'b1;
            s_nxt.ev.done = 1'b1;
          end
        end
      end
      default: s_nxt.st = ACT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  chk_div_min_tick: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.div < 7'h02 && $past(cfg.div) < 7'h02 && s_r.tick && s_r.st != ACT_IDLE) |-> ##1 !s_r.tick ##1 s_r.tick)
    else $error("core clock period wrong for small divider");

  sequence trig_direct;
    s_r.st == ACT_IDLE && trig && !cfg.ext_en;
  endsequence

  chk_direct_conv: assert property (@(posedge ref_clk) disable iff (rst)
    trig_direct |=> s_r.st == ACT_CONV && !s_r.ev.sampling)
    else $error("conversion did not start immediately");

  chk_ext_samp: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.st == ACT_IDLE && trig && cfg.ext_en && cfg.sample_extend_count != 10'h000) |=> s_r.st == ACT_SAMP && s_r.ev.sampling)
    else $error("sample extension not entered");

  chk_early_lead: assert property (@(posedge ref_clk) disable iff (rst)
    s_r.ev.early_irq |-> s_r.st == ACT_CONV && s_r.left == {2'b00, cfg.eis} + 5'h01)
    else $error("early interrupt lead wrong");

endmodule

/* verilog/act_ctrl.sv */
// converter timing control top: registers, shared core power, two dedicated cores, interrupts
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module act_ctrl
  import act_pkg::*;
#(
  parameter int PWRUP_CYC = ACT_PWRUP_CYC
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [1:0]  conv_trig,
  output logic [15:0]      rdata,
  output logic             shared_core_power_enable,
  output logic             shared_core_ready_flag,
  output logic [1:0]       core_sampling,
  output logic [1:0]       core_converting,
  output logic             irq
);

  typedef struct packed {
    logic        pwr;
    logic        rdy;
    logic [15:0] pwr_cnt;
    logic [1:0]  ext_en;
    logic [9:0]  samc0;
    logic [9:0]  samc1;
    logic [12:0] hi0;
    logic [12:0] hi1;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [1:0]  trig;
    logic [15:0] rdata;
    logic [1:0]  samp;
    logic [1:0]  conv;
    logic        irq;
  } top_t;

  top_t t_r;
  top_t t_nxt;
  act_core_cfg_t cfg [2];
  act_core_evt_t evt [2];
  logic [3:0]    ev_set;
  logic [15:0]   wmask;

  assign rdata                    = t_r.rdata;
  assign shared_core_power_enable = t_r.pwr;
  assign shared_core_ready_flag   = t_r.rdy;
  assign core_sampling            = t_r.samp;
  assign core_converting          = t_r.conv;
  assign irq                      = t_r.irq;

  always_comb begin
    // field layout of the control high register
    cfg[0].eis    = t_r.hi0[ACT_EIS_LSB +: 3];
    cfg[0].res    = t_r.hi0[ACT_RES_LSB +: 2];
    cfg[0].div    = t_r.hi0[ACT_DIV_LSB +: 7];
    cfg[0].sample_extend_count   = t_r.samc0;
    cfg[0].ext_en = t_r.ext_en[0];
    cfg[1].eis    = t_r.hi1[ACT_EIS_LSB +: 3];
    cfg[1].res    = t_r.hi1[ACT_RES_LSB +: 2];
    cfg[1].div    = t_r.hi1[ACT_DIV_LSB +: 7];
    cfg[1].sample_extend_count   = t_r.samc1;
    cfg[1].ext_en = t_r.ext_en[1];
    ev_set = {evt[1].early_irq, evt[0].early_irq, evt[1].done, evt[0].done};
  end

  // one sequencer per dedicated core
  for (genvar i = 0; i < 2; i++) begin : g_core
    act_core_seq u_seq (
      .ref_clk (ref_clk),
      .rst     (rst),
      .cfg     (cfg[i]),
      .trig    (t_r.trig[i]),
      .evt     (evt[i])
    );
  end

  always_comb begin
    t_nxt = t_r;
    wmask = 16'h0000;
    t_nxt.trig = conv_trig & {2{t_r.rdy}};
    // shared core power sequence; ready drops the cycle after power enable clears
    if (!t_r.pwr) begin
      t_nxt.pwr_cnt = 16'h0000;
      t_nxt.rdy = 1'b0;
    end else if (t_r.pwr_cnt >= PWRUP_CYC[15:0] - 16'h0001) begin
      t_nxt.rdy = 1'b1;
    end else begin
      t_nxt.pwr_cnt = t_r.pwr_cnt + 16'h0001;
    end
    if (wr_en) begin
      unique case (addr)
        ACT_OFF_PWR:      t_nxt.pwr = wdata[ACT_PWR_BIT];
        ACT_OFF_SDEL:     t_nxt.ext_en = wdata[1:0] & ACT_SDEL_MASK[1:0];
        ACT_OFF_C0_LO:    t_nxt.samc0 = wdata[9:0] & ACT_LO_MASK[9:0];
        ACT_OFF_C0_HI:    t_nxt.hi0 = wdata[12:0] & ACT_HI_MASK[12:0];
        ACT_OFF_C1_LO:    t_nxt.samc1 = wdata[9:0] & ACT_LO_MASK[9:0];
        ACT_OFF_C1_HI:    t_nxt.hi1 = wdata[12:0] & ACT_HI_MASK[12:0];
        ACT_OFF_IRQ_STAT: wmask = wdata & ACT_IRQ_MASK_W;
        ACT_OFF_IRQ_MASK: t_nxt.mask = wdata[3:0];
        ACT_OFF_TRIG:     t_nxt.trig = t_nxt.trig | (wdata[1:0] & {2{t_r.rdy}});
        default:          ;
      endcase
    end
    // set wins over a write-one clear in the same cycle
    t_nxt.stat = (t_r.stat & ~wmask[3:0]) | ev_set;
    t_nxt.irq = |(t_nxt.stat & t_nxt.mask);
    t_nxt.samp = {evt[1].sampling, evt[0].sampling};
    t_nxt.conv = {evt[1].converting, evt[0].converting};
    t_nxt.rdata = 16'h0000;
    if (rd_en) begin
      unique case (addr)
        ACT_OFF_PWR: begin
          t_nxt.rdata[ACT_RDY_BIT] = t_r.rdy;
          t_nxt.rdata[ACT_PWR_BIT] = t_r.pwr;
        end
        ACT_OFF_SDEL:     t_nxt.rdata = {14'h0000, t_r.ext_en};
        ACT_OFF_C0_LO:    t_nxt.rdata = {6'h00, t_r.samc0};
        ACT_OFF_C0_HI:    t_nxt.rdata = {3'h0, t_r.hi0} & ACT_HI_MASK;
        ACT_OFF_C1_LO:    t_nxt.rdata = {6'h00, t_r.samc1};
        ACT_OFF_C1_HI:    t_nxt.rdata = {3'h0, t_r.hi1} & ACT_HI_MASK;
        ACT_OFF_IRQ_STAT: t_nxt.rdata = {12'h000, t_r.stat};
        ACT_OFF_IRQ_MASK: t_nxt.rdata = {12'h000, t_r.mask};
        default:          t_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  chk_pwr_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && addr == ACT_OFF_PWR) |=> shared_core_power_enable == $past(wdata[ACT_PWR_BIT]))
    else $error("power enable not written");

  chk_rdy_off: assert property (@(posedge ref_clk) disable iff (rst)
    !shared_core_power_enable |=> !shared_core_ready_flag)
    else $error("ready set while core off");

  chk_rdy_rise: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(shared_core_ready_flag) |-> $past(shared_core_power_enable) && t_r.pwr_cnt == PWRUP_CYC[15:0] - 16'h0001)
    else $error("ready rose without power up time");

  chk_hi_unimpl: assert property (@(posedge ref_clk) disable iff (rst)
    $past(rd_en) && ($past(addr) == ACT_OFF_C0_HI || $past(addr) == ACT_OFF_C1_HI) |-> rdata[15:13] == 3'h0 && !rdata[7])
    else $error("unimplemented bits read nonzero");

  chk_hi_field: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && addr == ACT_OFF_C0_HI) |=> cfg[0].eis == $past(wdata[12:10]) && cfg[0].div == $past(wdata[6:0]))
    else $error("field layout wrong");

  chk_sdel_read: assert property (@(posedge ref_clk) disable iff (rst)
    $past(rd_en) && $past(addr) == ACT_OFF_SDEL |-> rdata[15:2] == 14'h0000)
    else $error("extension register upper bits nonzero");

  chk_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    irq |-> |(t_r.stat & t_r.mask))
    else $error("irq without masked status");

  chk_trig_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !shared_core_ready_flag |=> t_r.trig == 2'b00)
    else $error("trigger passed while shared core not ready");

  chk_rdy_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (shared_core_power_enable && shared_core_ready_flag) |=> shared_core_ready_flag)
    else $error("ready dropped while still powered");

  chk_sdel_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && addr == ACT_OFF_SDEL) |=> t_r.ext_en == $past(wdata[1:0]))
    else $error("extension enables not written");

  chk_lo_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && addr == ACT_OFF_C1_LO) |=> cfg[1].sample_extend_count == $past(wdata[9:0]))
    else $error("sample count not written");

  chk_hi1_field: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && addr == ACT_OFF_C1_HI) |=> cfg[1].eis == $past(wdata[12:10])
      && cfg[1].res == $past(wdata[9:8]) && cfg[1].div == $past(wdata[6:0]))
    else $error("core one field layout wrong");

  chk_early_stat: assert property (@(posedge ref_clk) disable iff (rst)
    evt[0].early_irq |=> t_r.stat[2])
    else $error("early event not latched in status");

  chk_pwr_read: assert property (@(posedge ref_clk) disable iff (rst)
    $past(rd_en) && $past(addr) == ACT_OFF_PWR |-> rdata[14:8] == 7'h00 && rdata[6:0] == 7'h00)
    else $error("power register unimplemented bits nonzero");

endmodule

/* sim/act_trig_model.sv */
// trigger source model standing in for the converter front end that fires conversions
`timescale 1ns/1ns
module act_trig_model (
  input  wire logic       ref_clk,
  input  wire logic       fire,
  input  wire logic       idx,
  output logic [1:0]      conv_trig
);
  initial conv_trig = 2'h0;
  // one-cycle pulse per request; rejecting it while not ready is left to the device
  always @(posedge ref_clk) begin
    conv_trig <= fire ? (2'h1 << idx) : 2'h0;
  end
endmodule

/* sim/act_ctrl_tb.sv */
// self-checking bench for the converter timing control block
`timescale 1ns/1ns
module act_ctrl_tb;
  import act_pkg::*;
  localparam int PU = 4;
  logic        ref_clk, rst, wr_en, rd_en, fire, fidx, pwr, rdy, irq;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, v;
  logic [1:0]  conv_trig, smp, cnv;
  int          bad_count, checked, cyc, ti, tc, nc, ns, ti0, tc0;

  act_ctrl #(.PWRUP_CYC(PU)) dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .conv_trig(conv_trig), .rdata(rdata), .shared_core_power_enable(pwr),
    .shared_core_ready_flag(rdy), .core_sampling(smp), .core_converting(cnv), .irq(irq));
  act_trig_model trg (.ref_clk(ref_clk), .fire(fire), .idx(fidx), .conv_trig(conv_trig));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [15:0] hi(input logic [2:0] e, input logic [1:0] r, input logic [6:0] d);
    return {3'h0, e, r, 1'b0, d};
  endfunction

  // runs one conversion; times counted from the trigger request
  task automatic conv(input int c, input logic [15:0] h, input logic [15:0] m, input logic pin);
    int i;
    wr(c ? ACT_OFF_C1_HI : ACT_OFF_C0_HI, h);
    wr(ACT_OFF_IRQ_MASK, m);
    wr(ACT_OFF_IRQ_STAT, 16'h000F);
    if (pin) begin
      @(posedge ref_clk);
      fire <= 1'b1; fidx <= c[0];
      @(posedge ref_clk);
      fire <= 1'b0;
    end else wr(ACT_OFF_TRIG, 16'h0001 << c);
    ti = -1; tc = -1; nc = 0; ns = 0;
    for (i = 1; i < 4000; i++) begin
      @(posedge ref_clk); #1;
      if (cnv[c] === 1'b1) begin
        nc++;
        if (tc < 0) tc = i;
      end
      if (smp[c] === 1'b0) ns++;
      if (irq === 1'b1 && ti < 0) ti = i;
      if (ti >= 0 && cnv[c] !== 1'b1) break;
    end
    wr(ACT_OFF_IRQ_STAT, 16'h000F);
  endtask

  task automatic t_regs;
    logic [15:0] ex [10] = '{16'h0000, 16'h0003, 16'h03FF, 16'h1F7F, 16'h03FF, 16'h1F7F,
                             16'h0000, 16'h000F, 16'h0000, 16'h0000};
    for (int a = 0; a < 10; a++) begin
      rd(a[3:0], v); chk(v, 16'h0000);
      wr(a[3:0], a == 0 ? 16'hFF7F : (a == 1 ? 16'hFCFF : 16'hFFFF));
      rd(a[3:0], v); chk(v, ex[a]);
    end
    // trigger above arrived while not ready, so nothing may convert
    repeat (10) @(posedge ref_clk);
    chk(cnv, 2'h0);
    chk(smp, 2'h3);
    for (int a = 1; a < 8; a++) wr(a[3:0], 16'h0000);
  endtask

  task automatic t_power;
    wr(ACT_OFF_PWR, 16'h0080);
    repeat (PU + 4) @(posedge ref_clk);
    rd(ACT_OFF_PWR, v); chk(v, 16'h8080);
    chk({pwr, rdy}, 2'h3);
    wr(ACT_OFF_PWR, 16'h0000);
    repeat (4) @(posedge ref_clk);
    rd(ACT_OFF_PWR, v); chk({v, rdy}, 17'h0);
    wr(ACT_OFF_PWR, 16'h0080);
    repeat (PU + 4) @(posedge ref_clk);
  endtask

  task automatic t_timing;
    int dv [5] = '{0, 1, 2, 3, 127};
    int bits [4] = '{6, 8, 10, 12};
    for (int k = 0; k < 5; k++) begin
      conv(0, hi(3'h0, 2'h3, dv[k][6:0]), 16'h0001, 1'b0);
      chk(nc, 14 * 2 * (dv[k] < 2 ? 1 : dv[k]));
    end
    for (int r = 0; r < 4; r++) begin
      conv(0, hi(3'h0, r[1:0], 7'h01), 16'h0001, 1'b0);
      chk(nc, (bits[r] + 2) * 2);
    end
    conv(0, hi(3'h0, 2'h3, 7'h01), 16'h0001, 1'b0);
    ti0 = ti;
    for (int e = 0; e < 8; e++) begin
      conv(0, hi(e[2:0], 2'h3, 7'h01), 16'h0004, 1'b0);
      chk(ti0 - ti, (e + 1) * 2);
    end
  endtask

  // core one through the trigger pin, without and then with an extended sample window
  task automatic t_extend;
    conv(1, hi(3'h1, 2'h3, 7'h02), 16'h0002, 1'b1);
    ti0 = ti; tc0 = tc;
    chk(ns, 14 * 4);
    wr(ACT_OFF_C1_LO, 16'h0005);
    wr(ACT_OFF_SDEL, 16'h0002);
    conv(1, hi(3'h1, 2'h3, 7'h02), 16'h0002, 1'b1);
    chk(tc - tc0, 5 * 4);
    chk(ti - ti0, 5 * 4);
    chk(nc, 14 * 4);
    chk(ns, 14 * 4);
    wr(ACT_OFF_SDEL, 16'h0000);
  endtask

  task automatic t_irq;
    wr(ACT_OFF_C0_HI, hi(3'h0, 2'h3, 7'h01));
    wr(ACT_OFF_IRQ_MASK, 16'h0000);
    wr(ACT_OFF_TRIG, 16'h0001);
    repeat (60) @(posedge ref_clk);
    chk(irq, 1'b0);
    rd(ACT_OFF_IRQ_STAT, v); chk(v, 16'h0005);
    wr(ACT_OFF_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    wr(ACT_OFF_IRQ_STAT, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    rd(ACT_OFF_IRQ_STAT, v); chk(v, 16'h0004);
  endtask

  initial begin
    rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; fire = 1'b0; fidx = 1'b0;
    addr = 4'h0; wdata = 16'h0000;
    bad_count = 0; checked = 0; cyc = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_power();
    t_timing();
    t_extend();
    t_irq();
    wrap_up();
  end
endmodule
